// ### logic/ips_top.sv
`timescale 1ns/10ps
`default_nettype none
module ips_top (
    input wire logic clock,                          // System clock, 100 MHz
    input wire logic rst_n,                          // Async reset, active low
    input wire logic wb_cyc_i,                       // Wishbone cycle
    input wire logic wb_stb_i,                       // Wishbone strobe
    input wire logic wb_we_i,                        // Wishbone write enable
    input wire logic [9:0] wb_adr_i,                 // Byte address
    input wire logic [3:0] wb_sel_i,                 // Byte lane selects
    input wire logic [31:0] wb_dat_i,                // Write data
    output logic [31:0] wb_dat_o,                    // Read data
    output logic wb_ack_o,                           // Acknowledge
    input wire logic [ips_pkg::NUM_SRC-1:0] irq_flag, // Request flags, rank order
    input wire logic [1:0] ext_edge_mode,            // External 1/0 edge mode
    input wire ips_pkg::ips_core_t core_in,          // Core instruction status
    output ips_pkg::ips_call_t call_out,             // Call requests to core
    output logic [ips_pkg::NUM_SRC-1:0] flag_clear,  // One-cycle flag clears
    output logic [ips_pkg::NUM_LVL-1:0] in_service   // Levels being served
);
    // Priority registers
    logic [7:0] prio_lo_a;
    logic [7:0] prio_hi_a;
    logic [7:0] prio_lo_b;
    logic [7:0] prio_hi_b;
    logic [7:0] prio_lo_c;
    logic [7:0] prio_hi_c;

    // Resolution signals
    logic [ips_pkg::NUM_SRC-1:0] src_lo;
    logic [ips_pkg::NUM_SRC-1:0] src_hi;
    logic [ips_pkg::LVL_W-1:0] src_level [0:ips_pkg::NUM_SRC-1];
    logic win_valid;
    logic [4:0] win_src;
    logic [ips_pkg::LVL_W-1:0] win_level;
    logic level_blocked;
    logic accept;

    // Sequencer
    ips_pkg::ips_state_t state;
    ips_pkg::ips_state_t next_state;
    logic [4:0] call_src;
    logic [ips_pkg::PC_W-1:0] saved_pc;
    logic [ips_pkg::NUM_SRC-1:0] clear_mask;

    // Bus
    logic wb_req;
    logic [7:0] wb_idx;
    logic wr_en;
    logic [31:0] next_rdata;

    // Bus handshake
    // A request is seen when cycle and strobe are high
    // And no acknowledge is outstanding
    // The acknowledge follows one edge later
    // It stands for one cycle, then drops
    // Masking by the acknowledge stops a double write
    // When the master holds the strobe through the ack cycle
    // Lane 0 carries all write data; the status word also reads on lane 1; other lane selects are ignored
    // A write with lane 0 deselected changes nothing
    // Index is the byte address divided by four
    // Unmapped indices read zero and ignore writes
    // No error response exists on this bus
    // Read data is registered with the acknowledge
    // It then holds until the next read
    // Writes leave the read data register untouched
    // A status word reports service state and last source
    // That word is read only; writes to it are dropped
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_idx = wb_adr_i[9:2];
    assign wr_en = wb_req && wb_we_i && wb_sel_i[0];

    // Acknowledge one cycle after the strobe, then drop for a cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Priority register writes; the bus writes on the acked request only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prio_lo_a <= ips_pkg::RST_PRIO;
            prio_hi_a <= ips_pkg::RST_PRIO;
            prio_lo_b <= ips_pkg::RST_PRIO;
            prio_hi_b <= ips_pkg::RST_PRIO;
            prio_lo_c <= ips_pkg::RST_PRIO;
            prio_hi_c <= ips_pkg::RST_PRIO;
        end else if (wr_en) begin
            case (wb_idx)
                ips_pkg::IDX_PRIO_LO_A: begin
                    prio_lo_a <= wb_dat_i[7:0] & ips_pkg::MASK_A;
                end
                ips_pkg::IDX_PRIO_HI_A: begin
                    prio_hi_a <= wb_dat_i[7:0] & ips_pkg::MASK_A;
                end
                ips_pkg::IDX_PRIO_LO_B: begin
                    prio_lo_b <= wb_dat_i[7:0] & ips_pkg::MASK_B;
                end
                ips_pkg::IDX_PRIO_HI_B: begin
                    prio_hi_b <= wb_dat_i[7:0] & ips_pkg::MASK_B;
                end
                ips_pkg::IDX_PRIO_LO_C: begin
                    prio_lo_c <= wb_dat_i[7:0] & ips_pkg::MASK_C;
                end
                ips_pkg::IDX_PRIO_HI_C: begin
                    prio_hi_c <= wb_dat_i[7:0] & ips_pkg::MASK_C;
                end
                default: begin
                    prio_lo_a <= prio_lo_a;
                end
            endcase
        end
    end

    // Read mux; unmapped addresses answer zero rather than error
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_idx)
            ips_pkg::IDX_PRIO_LO_A: next_rdata[7:0] = prio_lo_a;
            ips_pkg::IDX_PRIO_HI_A: next_rdata[7:0] = prio_hi_a;
            ips_pkg::IDX_PRIO_LO_B: next_rdata[7:0] = prio_lo_b;
            ips_pkg::IDX_PRIO_HI_B: next_rdata[7:0] = prio_hi_b;
            ips_pkg::IDX_PRIO_LO_C: next_rdata[7:0] = prio_lo_c;
            ips_pkg::IDX_PRIO_HI_C: next_rdata[7:0] = prio_hi_c;
            ips_pkg::IDX_SERVICE_STATUS: begin
                next_rdata[ips_pkg::STAT_INSVC_LSB +: ips_pkg::NUM_LVL] = in_service;
                next_rdata[ips_pkg::STAT_BUSY_BIT] = (state != ips_pkg::ST_IDLE);
                next_rdata[ips_pkg::STAT_SRC_LSB +: 5] = call_src;
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered together with the acknowledge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // Priority scheme overview
    // Each source owns one low bit and one high bit
    // Low bits live in the three low registers
    // High bits live in the three high registers
    // The gather function reorders both into rank order
    // Bit 0 of the gathered vectors is rank 1
    // Bit 17 of the gathered vectors is the last rank
    // Level is the high bit above the low bit
    // Level 3 is the most urgent, level 0 the least
    // Unused register bits are masked on write
    // So they never feed a level and always read zero
    // Register writes take effect at the bus edge
    // A new level applies from the next poll onward
    // No shadow copy: software sees the live setting
    // Trade-off: a write during a call is not held off here
    // The core itself blocks the call on such writes
    // Resolution is pure logic, one cycle deep
    // Eighteen compares chain through one loop
    // Timing margin ample at the system clock rate
    // Ties resolve to the lowest rank index
    // Because only a strictly higher level replaces a winner
    // The scan therefore keeps the first of equals
    // Per-source level from its low and high bit
    assign src_lo = ips_pkg::gather(prio_lo_a, prio_lo_b, prio_lo_c);
    assign src_hi = ips_pkg::gather(prio_hi_a, prio_hi_b, prio_hi_c);
    generate
        for (genvar s = 0; s < ips_pkg::NUM_SRC; s++) begin : g_level
            assign src_level[s] = {src_hi[s], src_lo[s]};
        end
    endgenerate

    // Live flags polled each cycle with no latch of past requests
    always_comb begin
        win_valid = 1'b0;
        win_src = 5'h00;
        win_level = 2'h0;
        for (int s = 0; s < ips_pkg::NUM_SRC; s++) begin
            // Strictly higher level wins; ties keep the lower rank index
            if (irq_flag[s] && (!win_valid || src_level[s] > win_level)) begin
                win_valid = 1'b1;
                win_src = 5'(s);
                win_level = src_level[s];
            end
        end
    end

    // Any served level at or above the winner's level blocks it
    always_comb begin
        level_blocked = 1'b0;
        for (int l = 0; l < ips_pkg::NUM_LVL; l++) begin
            if (in_service[l] && (2'(l) >= win_level)) begin
                level_blocked = 1'b1;
            end
        end
    end

    // All three conditions in the polling cycle; nothing is held over
    assign accept = win_valid && !level_blocked
                    && core_in.last_cycle
                    && !core_in.touches_prio && !core_in.is_return_from_interrupt
                    && (state == ips_pkg::ST_IDLE);

    // Call timing walk, accept edge called E
    // Edge E: winner, level and counter captured
    // Edge E: sequencer leaves idle for the low push
    // After E: hold and push high, low counter byte out
    // After E: flag clear pulse for auto-clear sources
    // After E: in-service bit of the winner's level set
    // After E+1: second push, high counter byte out
    // After E+2: load strobe with the vector address
    // After E+3: hold alone, the core fetches the vector
    // After E+4: hold low, core runs the handler
    // Four cycles of hold in total
    // Plus the detect cycle makes five at minimum
    // Push data of the first byte comes straight from the core
    // Because the saved copy is only written at edge E
    // Later bytes read the saved copy, which is stable
    // The status word is never pushed
    // A handler that needs it must save it itself
    // Next accept only once the sequencer is idle again
    // Hold covers that whole span, so the core stays frozen
    // While frozen the core must not report a final cycle
    // Otherwise a call could start before the vector load
    // The idle check in the accept term guards that case
    // Vector table is indexed by the captured source
    // Not by the live winner, which may have moved on
    // Flags may drop during the call without effect
    // The call, once accepted, always runs to the end
    // Limitation: reset during a call abandons the stack
    // The core must reset its stack pointer too
    // Call sequencer: four cycles after the detect cycle
    always_comb begin
        case (state)
            ips_pkg::ST_IDLE: next_state = accept ? ips_pkg::ST_PUSH_LO : ips_pkg::ST_IDLE;
            ips_pkg::ST_PUSH_LO: next_state = ips_pkg::ST_PUSH_HI;
            ips_pkg::ST_PUSH_HI: next_state = ips_pkg::ST_VECTOR;
            ips_pkg::ST_VECTOR: next_state = ips_pkg::ST_FINISH;
            ips_pkg::ST_FINISH: next_state = ips_pkg::ST_IDLE;
            default: next_state = ips_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ips_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Capture winner and return address at acceptance
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            call_src <= 5'h00;
            saved_pc <= 16'h0000;
        end else if (accept) begin
            call_src <= win_src;
            saved_pc <= core_in.pc;
        end
    end

    // Call outputs registered; only the counter is pushed, never status
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            call_out <= '0;
        end else begin
            call_out.hold <= (next_state != ips_pkg::ST_IDLE);
            call_out.push <= (next_state == ips_pkg::ST_PUSH_LO)
                             || (next_state == ips_pkg::ST_PUSH_HI);
            if (next_state == ips_pkg::ST_PUSH_LO) begin
                call_out.push_data <= accept ? core_in.pc[7:0] : saved_pc[7:0];
            end else if (next_state == ips_pkg::ST_PUSH_HI) begin
                call_out.push_data <= saved_pc[15:8];
            end else begin
                call_out.push_data <= 8'h00;
            end
            call_out.load_pc <= (next_state == ips_pkg::ST_VECTOR);
            call_out.vector <= (next_state == ips_pkg::ST_VECTOR)
                               ? ips_pkg::VEC_TABLE[call_src] : 16'h0000;
        end
    end

    // Which flags the hardware clears depends on source and edge mode
    always_comb begin
        clear_mask = ips_pkg::AUTOCLR_MASK;
        clear_mask[ips_pkg::SRC_EXT0] = ext_edge_mode[0];
        clear_mask[ips_pkg::SRC_EXT1] = ext_edge_mode[1];
    end

    // One-cycle clear pulse for the accepted source
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_clear <= '0;
        end else begin
            for (int s = 0; s < ips_pkg::NUM_SRC; s++) begin
                flag_clear[s] <= accept && (win_src == 5'(s)) && clear_mask[s];
            end
        end
    end

    // Service tracking
    // One bit per level records a handler in progress
    // Entry sets the bit of the accepted level
    // A return clears the highest bit that is set
    // Nesting only goes upward in level
    // So the highest set bit is always the newest handler
    // Lower bits stay set for the preempted handlers
    // Each resumes as its own return arrives
    // The blocking compare uses every set bit
    // Any set bit at or above a level blocks that level
    // Equal levels cannot preempt one another
    // Lower levels wait until all higher returns are done
    // A plain return tells the block nothing
    // So its level stays busy and blocks
    // Software that ends a handler that way locks its level
    // Reset, or a later return that finds it highest, clears such a stuck bit
    // Accept wins over a return in the same cycle
    // The core never reports both at once
    // Because a return instruction itself blocks the call
    // A return with no bit set is harmless
    // It leaves all bits clear
    // The bits also feed the status word
    // Software may read them to see the nesting depth
    // Bit 0 is level 0, bit 3 is level 3
    // The output port mirrors the same register
    // In-service bits: set on acceptance, highest cleared by a return
    // A plain subroutine return has no input here, so service stays set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_service <= '0;
        end else if (accept) begin
            in_service[win_level] <= 1'b1;
        end else if (core_in.return_from_interrupt_done) begin
            // Top bit ends first, matching nested entry order
            if (in_service[3]) begin
                in_service[3] <= 1'b0;
            end else if (in_service[2]) begin
                in_service[2] <= 1'b0;
            end else if (in_service[1]) begin
                in_service[1] <= 1'b0;
            end else begin
                in_service[0] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/ips_pkg.sv
`default_nettype none
package ips_pkg;
    // Source count and level width
    localparam int NUM_SRC = 18;
    localparam int LVL_W = 2;
    localparam int NUM_LVL = 4;
    localparam int PC_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PRIO_HI_A = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LO_A = 8'hB8;
    localparam logic [7:0] IDX_PRIO_LO_B = 8'hEF;
    localparam logic [7:0] IDX_PRIO_HI_B = 8'hF7;
    localparam logic [7:0] IDX_PRIO_LO_C = 8'hFE;
    localparam logic [7:0] IDX_PRIO_HI_C = 8'hFF;
    localparam logic [7:0] IDX_SERVICE_STATUS = 8'h80;

    // Reset values
    localparam logic [7:0] RST_PRIO = 8'h00;

    // Writable bit masks; unused bits read as zero
    localparam logic [7:0] MASK_A = 8'h7F;
    localparam logic [7:0] MASK_B = 8'hFF;
    localparam logic [7:0] MASK_C = 8'h07;

    // Status register field positions
    localparam int STAT_INSVC_LSB = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_SRC_LSB = 8;

    // Source indices in natural rank order, rank 1 first
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 6;

    // Flags that hardware clears on vectoring: timers 0, 1 and 3
    localparam logic [NUM_SRC-1:0] AUTOCLR_MASK = 18'h10108;

    // Cycles of the hardware call after the detect cycle
    localparam int CALL_CYCLES = 4;

    // Vector addresses, indexed by natural rank
    localparam logic [PC_W-1:0] VEC_TABLE [0:NUM_SRC-1] = '{
        16'h0003, 16'h0043, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
        16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073, 16'h004B,
        16'h002B, 16'h0063, 16'h006B, 16'h007B, 16'h0083, 16'h008B
    };

    // Call sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_PUSH_LO = 5'h02,
        ST_PUSH_HI = 5'h04,
        ST_VECTOR  = 5'h08,
        ST_FINISH  = 5'h10
    } ips_state_t;

    // Per-cycle status from the core
    typedef struct packed {
        logic last_cycle;   // Final cycle of current instruction
        logic touches_prio; // Instruction writes an enable or priority bit
        logic is_return_from_interrupt;      // Instruction is a return-from-interrupt
        logic return_from_interrupt_done;    // Return-from-interrupt completes this cycle
        logic [PC_W-1:0] pc;
    } ips_core_t;

    // Call requests toward the core
    typedef struct packed {
        logic hold;              // Core stalls while the call runs
        logic push;              // Push one stack byte
        logic [7:0] push_data;   // Byte to push, low byte first
        logic load_pc;           // Load program counter
        logic [PC_W-1:0] vector; // Vector address to load
    } ips_call_t;

    // Gather per-source bits from three priority register pairs
    function automatic logic [NUM_SRC-1:0] gather(input logic [7:0] a,
                                                  input logic [7:0] b,
                                                  input logic [7:0] c);
        gather = {c[2], c[1], c[0], b[3], b[2], b[7], b[6], b[5], a[4],
                  a[3], b[1], a[2], a[6], b[0], a[1], b[4], a[5], a[0]};
    endfunction
endpackage
`default_nettype wire

// ### bench/ips_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module ips_core_model (
    input wire logic clock,              // System clock
    input wire logic rst_n,              // Async reset, active low
    input wire ips_pkg::ips_call_t call, // Call requests from block
    input wire logic blk_last,           // Hold off final instruction cycle
    input wire logic blk_prio,           // Instruction writes priority bits
    input wire logic return_from_interrupt_req,           // Run a return-from-interrupt
    output ips_pkg::ips_core_t core,     // Status toward block
    output logic [15:0] top              // Return address on stack top
);
    logic [15:0] pc;
    logic [7:0] mem [0:15];
    logic [3:0] sp;
    // Stack grows by bytes; core stalls under hold, so pc stays put
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc <= 16'h1234;
            sp <= 4'h0;
        end else if (call.push) begin
            mem[sp] <= call.push_data;
            sp <= sp + 4'h1;
        end else if (call.load_pc) begin
            pc <= call.vector;
        end else if (return_from_interrupt_req) begin
            pc <= top;
            sp <= sp - 4'h2;
        end
    end
    // Low byte pushed first, so high byte sits on top
    assign top = {mem[sp - 4'h1], mem[sp - 4'h2]};
    assign core = '{!blk_last, blk_prio, return_from_interrupt_req, return_from_interrupt_req, pc};
endmodule
`default_nettype wire

// ### bench/ips_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module ips_top_props (
    input wire logic clock,                         // System clock
    input wire logic rst_n,                         // Async reset
    input wire logic wb_cyc_i,                      // Bus cycle
    input wire logic wb_stb_i,                      // Bus strobe
    input wire logic wb_ack_o,                      // Bus acknowledge
    input wire logic [1:0] ext_edge_mode,           // Edge modes
    input wire ips_pkg::ips_core_t core_in,         // Core status
    input wire ips_pkg::ips_call_t call_out,        // Call requests
    input wire logic [ips_pkg::NUM_SRC-1:0] flag_clear, // Flag clears
    input wire logic [ips_pkg::NUM_LVL-1:0] in_service  // Levels served
);
    logic [3:0] isvc_pop;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Highest served level dropped by a return
    assign isvc_pop = in_service[3] ? {1'b0, in_service[2:0]} :
        in_service[2] ? {2'b0, in_service[1:0]} :
        in_service[1] ? {3'b0, in_service[0]} : 4'h0;
    AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    AST_SEQ: assert property ($rose(call_out.hold) |-> call_out.push ##1 call_out.push
        ##1 call_out.load_pc ##1 (call_out.hold && !call_out.push) ##1 !call_out.hold)
        else $error("call sequence wrong");
    AST_PC: assert property ($rose(call_out.hold) |-> call_out.push_data == core_in.pc[7:0]
        ##1 call_out.push_data == core_in.pc[15:8]) else $error("pushed pc wrong");
    AST_GATE: assert property ($rose(call_out.hold) |-> $past(core_in.last_cycle)
        && !$past(core_in.touches_prio) && !$past(core_in.is_return_from_interrupt)) else $error("call gated");
    AST_NEST: assert property ($rose(call_out.hold) |->
        (in_service ^ $past(in_service)) > $past(in_service)) else $error("nesting wrong");
    AST_RETURN_FROM_INTERRUPT: assert property (core_in.return_from_interrupt_done |=> in_service == $past(isvc_pop))
        else $error("return not tracked");
    AST_CLR_WHEN: assert property (|flag_clear |-> $rose(call_out.hold))
        else $error("clear outside call");
    AST_CLR_MASK: assert property (|flag_clear |-> (flag_clear & ~(ips_pkg::AUTOCLR_MASK
        | {11'h0, $past(ext_edge_mode[1]), 5'h0, $past(ext_edge_mode[0])})) == 18'h0)
        else $error("clear of wrong source");
    AST_ONE_CLR: assert property (|flag_clear |-> $onehot(flag_clear))
        else $error("several sources cleared");
    cover property ($rose(call_out.hold));
    cover property (in_service == 4'h6);
    cover property (core_in.return_from_interrupt_done && in_service[3]);
endmodule
bind ips_top ips_top_props u_props (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_edge_mode(ext_edge_mode),
    .core_in(core_in), .call_out(call_out), .flag_clear(flag_clear), .in_service(in_service));
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [17:0] irq_flag = 18'h0, flag_clear;
    logic [1:0] ext_edge_mode = 2'h0;
    logic blk_last = 1'b0, blk_prio = 1'b0, return_from_interrupt_req = 1'b0;
    logic [15:0] top;
    logic [3:0] in_service;
    logic [7:0] q;
    ips_pkg::ips_core_t core_in;
    ips_pkg::ips_call_t call_out;
    int num_errors = 0, compares = 0;
    always #5 clock = ~clock;
    ips_top uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_flag(irq_flag),
        .ext_edge_mode(ext_edge_mode), .core_in(core_in), .call_out(call_out),
        .flag_clear(flag_clear), .in_service(in_service));
    ips_core_model core (.clock(clock), .rst_n(rst_n), .call(call_out), .blk_last(blk_last),
        .blk_prio(blk_prio), .return_from_interrupt_req(return_from_interrupt_req), .core(core_in), .top(top));
    task end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle; ack and data taken at the rising edge, released there
    task wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task t_regs;
        logic [7:0] idx [6];
        logic [7:0] msk [6];
        idx = '{ips_pkg::IDX_PRIO_HI_A, ips_pkg::IDX_PRIO_LO_A, ips_pkg::IDX_PRIO_LO_B,
            ips_pkg::IDX_PRIO_HI_B, ips_pkg::IDX_PRIO_LO_C, ips_pkg::IDX_PRIO_HI_C};
        msk = '{8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'h07, 8'h07};
        foreach (idx[i]) begin
            wb(1'b0, idx[i], 8'h00);
            chk("reset", 32'h0, 32'(q));
            wb(1'b1, idx[i], 8'hFF);
            wb(1'b0, idx[i], 8'h00);
            chk("rw", 32'(msk[i]), 32'(q));
            wb(1'b1, idx[i], 8'h00);
        end
        wb(1'b1, 8'h10, 8'hFF);
        wb(1'b0, 8'h10, 8'h00);
        chk("unmapped", 32'h0, 32'(q));
    endtask
    // Raise flags, wait for the vector load, judge vector, clears, stack
    task t_call(input logic [17:0] f, input logic [15:0] v, input logic [17:0] c);
        logic [15:0] p;
        logic [17:0] seen;
        int n;
        p = core_in.pc;
        seen = 18'h0;
        n = 0;
        @(posedge clock) irq_flag <= f;
        do begin
            @(negedge clock);
            seen |= flag_clear;
            n++;
        end while (call_out.load_pc !== 1'b1 && n < 40);
        chk("vector", 32'(v), 32'(call_out.vector));
        chk("clear", 32'(c), 32'(seen));
        @(posedge clock) irq_flag <= 18'h0;
        repeat (3) @(negedge clock);
        chk("stacked pc", 32'(p), 32'(top));
    endtask
    task return_from_interrupt(input logic [3:0] e);
        @(posedge clock) return_from_interrupt_req <= 1'b1;
        @(posedge clock) return_from_interrupt_req <= 1'b0;
        @(negedge clock);
        chk("in_service", 32'(e), 32'(in_service));
    endtask
    task no_call(input int n);
        int k;
        k = 0;
        repeat (n) begin
            @(negedge clock);
            if (call_out.hold !== 1'b0)
                k++;
        end
        chk("calls", 32'h0, 32'(k));
    endtask
    task t_levels;
        wb(1'b1, ips_pkg::IDX_PRIO_LO_A, 8'h04);
        wb(1'b1, ips_pkg::IDX_PRIO_HI_A, 8'h06);
        wb(1'b1, ips_pkg::IDX_PRIO_LO_C, 8'h04);
        @(posedge clock) ext_edge_mode <= 2'b10;
        t_call(18'h20049, 16'h0013, 18'h00040);
        chk("in_service", 32'h8, 32'(in_service));
        @(posedge clock) irq_flag <= 18'h00008;
        no_call(20);
        @(posedge clock) irq_flag <= 18'h0;
        return_from_interrupt(4'h0);
        no_call(10);
        t_call(18'h20000, 16'h008B, 18'h0);
        t_call(18'h00008, 16'h000B, 18'h00008);
        chk("in_service", 32'h6, 32'(in_service));
        return_from_interrupt(4'h2);
        return_from_interrupt(4'h0);
    endtask
    task t_block;
        @(posedge clock) begin
            blk_last <= 1'b1;
            irq_flag <= 18'h00200;
        end
        no_call(10);
        @(posedge clock) {blk_last, blk_prio} <= 2'b01;
        no_call(10);
        @(posedge clock) blk_prio <= 1'b0;
        t_call(18'h00200, 16'h0023, 18'h0);
        return_from_interrupt(4'h0);
    endtask
    // Generous cap; the whole run needs a few hundred cycles
    initial begin
        #300000;
        num_errors++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_regs;
        t_call(18'h00049, 16'h0003, 18'h0);
        return_from_interrupt(4'h0);
        t_levels;
        t_block;
        end_sim;
    end
endmodule
`default_nettype wire
